// ---- srb_pkg.sv ----
package srb_pkg;
	localparam int SEG_COUNT = 4;
	localparam int SEG_WIDTH = 128;
	localparam int EMPTY_WIDTH = 4;
	localparam int SYNC_STAGES = 3;
	localparam int CLK_PERIOD_PS = 40000;
	localparam int PATH_RESET_MIN_PS = 5000;
	localparam int PATH_RESET_MIN_CYCLES =
		(PATH_RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic SYNC_RESET_LEVEL = 1'h1;
	typedef logic [SEG_WIDTH-1:0] srb_seg_t;
	typedef logic [EMPTY_WIDTH-1:0] srb_empty_t;
endpackage

// ---- srb_reset_sync.sv ----
`timescale 1ns/1ps
module srb_reset_sync
	import srb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic path_reset_pin,
	output logic path_reset_sync
);
	logic [SYNC_STAGES-1:0] stage;
	logic [SYNC_STAGES-1:0] next_stage;
	logic filtered;
	logic next_filtered;

	// three stages; level changes once stages two and three agree
	always_comb begin
		next_stage = {stage[SYNC_STAGES-2:0], path_reset_pin};
		next_filtered = filtered;
		if (stage[SYNC_STAGES-1] == stage[SYNC_STAGES-2]) begin
			next_filtered = stage[SYNC_STAGES-1];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stage <= {SYNC_STAGES{SYNC_RESET_LEVEL}};
			filtered <= SYNC_RESET_LEVEL;
		end else begin
			stage <= next_stage;
			filtered <= next_filtered;
		end
	end

	assign path_reset_sync = filtered;

	sequence pin_held_s;
		path_reset_pin [*3];
	endsequence

	sequence pin_low_s;
		!path_reset_pin [*3];
	endsequence

	chk_sync_assert: assert property (@(posedge core_clk) disable iff (reset)
		pin_held_s |-> ##[1:3] path_reset_sync)
		else $error("path reset not synchronised high in time");

	chk_sync_release: assert property (@(posedge core_clk) disable iff (reset)
		pin_low_s ##1 !path_reset_pin |-> ##[0:3] !path_reset_sync)
		else $error("path reset not synchronised low in time");
endmodule

// ---- srb_rx_bus.sv ----
`timescale 1ns/1ps
module srb_rx_bus
	import srb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic rx_path_reset,
	input wire logic tx_path_reset,
	output logic tx_path_reset_sync,
	input wire logic [SEG_COUNT-1:0] mac_seg_valid,
	input wire srb_seg_t mac_seg_data [SEG_COUNT],
	input wire logic [SEG_COUNT-1:0] mac_seg_first,
	input wire logic [SEG_COUNT-1:0] mac_seg_last,
	input wire logic [SEG_COUNT-1:0] mac_seg_bad,
	input wire srb_empty_t mac_seg_empty [SEG_COUNT],
	output logic [SEG_COUNT-1:0] rx_segment_valid,
	output srb_seg_t rx_segment_data [SEG_COUNT],
	output logic [SEG_COUNT-1:0] rx_segment_first,
	output logic [SEG_COUNT-1:0] rx_segment_last,
	output logic [SEG_COUNT-1:0] rx_segment_bad,
	output srb_empty_t rx_segment_empty_bytes [SEG_COUNT]
);
	localparam int SLOT_W = $clog2(SEG_COUNT) + 1;

	logic rx_reset_sync;
	logic hold;
	logic [SEG_COUNT-1:0] next_valid;
	srb_seg_t next_data [SEG_COUNT];
	logic [SEG_COUNT-1:0] next_first;
	logic [SEG_COUNT-1:0] next_last;
	logic [SEG_COUNT-1:0] next_bad;
	srb_empty_t next_empty [SEG_COUNT];

	// path resets brought into core_clk
	srb_reset_sync u_rx_reset_sync (
		.core_clk(core_clk),
		.reset(reset),
		.path_reset_pin(rx_path_reset),
		.path_reset_sync(rx_reset_sync)
	);

	srb_reset_sync u_tx_reset_sync (
		.core_clk(core_clk),
		.reset(reset),
		.path_reset_pin(tx_path_reset),
		.path_reset_sync(tx_path_reset_sync)
	);

	assign hold = reset | rx_reset_sync;

	// end-of-packet qualification
	function automatic logic ends_here(input logic valid, input logic last);
		ends_here = valid & last;
	endfunction

	// pack valid segments downward from slot zero
	always_comb begin
		logic [SLOT_W-1:0] slot;
		slot = '0;
		next_valid = '0;
		next_first = '0;
		next_last = '0;
		next_bad = '0;
		for (int s = 0; s < SEG_COUNT; s++) begin
			next_data[s] = '0;
			next_empty[s] = '0;
		end
		if (!hold) begin
			for (int i = 0; i < SEG_COUNT; i++) begin
				if (mac_seg_valid[i]) begin
					next_valid[slot[SLOT_W-2:0]] = 1'h1;
					next_data[slot[SLOT_W-2:0]] = mac_seg_data[i];
					next_first[slot[SLOT_W-2:0]] = mac_seg_first[i];
					next_last[slot[SLOT_W-2:0]] = mac_seg_last[i];
					next_bad[slot[SLOT_W-2:0]] =
						ends_here(1'h1, mac_seg_last[i]) & mac_seg_bad[i];
					if (ends_here(1'h1, mac_seg_last[i])) begin
						next_empty[slot[SLOT_W-2:0]] = mac_seg_empty[i];
					end
					slot = slot + SLOT_W'(1);
				end
			end
		end
	end

	// outputs launched on the rising edge
	always_ff @(posedge core_clk) begin
		if (hold) begin
			rx_segment_valid <= '0;
			rx_segment_first <= '0;
			rx_segment_last <= '0;
			rx_segment_bad <= '0;
			for (int s = 0; s < SEG_COUNT; s++) begin
				rx_segment_data[s] <= '0;
				rx_segment_empty_bytes[s] <= '0;
			end
		end else begin
			rx_segment_valid <= next_valid;
			rx_segment_first <= next_first;
			rx_segment_last <= next_last;
			rx_segment_bad <= next_bad;
			for (int s = 0; s < SEG_COUNT; s++) begin
				rx_segment_data[s] <= next_data[s];
				rx_segment_empty_bytes[s] <= next_empty[s];
			end
		end
	end

	// helper views for checks
	logic [SEG_COUNT-1:0] empty_set;
	logic [SEG_COUNT-1:0] data_set;
	always_comb begin
		for (int s = 0; s < SEG_COUNT; s++) begin
			empty_set[s] = |rx_segment_empty_bytes[s];
			data_set[s] = |rx_segment_data[s];
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	sequence rx_held_s;
		rx_reset_sync ##1 1'b1;
	endsequence

	chk_valid_in_reset: assert property (rx_reset_sync |=> rx_segment_valid == '0)
		else $error("segment valid high during receive reset");

	chk_first_qual: assert property ((rx_segment_first & ~rx_segment_valid) == '0)
		else $error("first flag without valid");

	chk_last_qual: assert property ((rx_segment_last & ~rx_segment_valid) == '0)
		else $error("last flag without valid");

	chk_bad_qual: assert property (
		(rx_segment_bad & ~(rx_segment_valid & rx_segment_last)) == '0)
		else $error("bad flag outside final transfer");

	chk_empty_qual: assert property (
		(empty_set & ~(rx_segment_valid & rx_segment_last)) == '0)
		else $error("empty count outside final transfer");

	chk_valid_packed: assert property (
		(rx_segment_valid & (rx_segment_valid + SEG_COUNT'(1))) == '0)
		else $error("valid segments not packed from zero");

	chk_idle_data: assert property ((data_set & ~rx_segment_valid) == '0)
		else $error("data driven on invalid segment");

	chk_segments_kept: assert property (!hold |=>
		$countones(rx_segment_valid) == $countones($past(mac_seg_valid)))
		else $error("valid segment count lost");

	chk_slot0_data: assert property ((!hold && mac_seg_valid[0]) |=>
		rx_segment_valid[0] && rx_segment_data[0] == $past(mac_seg_data[0]))
		else $error("segment zero data not carried");

	chk_reset_recover: assert property (rx_held_s ##1 !rx_reset_sync [*2] |->
		rx_segment_valid == $past(next_valid))
		else $error("bus not live after reset release");

	sequence seg0_taken_s;
		!hold && mac_seg_valid[0];
	endsequence

	sequence seg0_closes_s;
		!hold && ends_here(mac_seg_valid[0], mac_seg_last[0]);
	endsequence

	chk_first_carried: assert property (seg0_taken_s |=>
		rx_segment_first[0] == $past(mac_seg_first[0]))
		else $error("start flag not carried");

	chk_last_carried: assert property (seg0_taken_s |=>
		rx_segment_last[0] == $past(mac_seg_last[0]))
		else $error("end flag not carried");

	chk_bad_carried: assert property (seg0_closes_s |=>
		rx_segment_bad[0] == $past(mac_seg_bad[0]))
		else $error("error flag not carried");

	chk_empty_carried: assert property (seg0_closes_s |=>
		rx_segment_empty_bytes[0] == $past(mac_seg_empty[0]))
		else $error("empty count not carried");

	chk_hold_quiet: assert property (hold |=>
		(rx_segment_valid | rx_segment_first | rx_segment_last | rx_segment_bad) == '0)
		else $error("segment flags raised while held");

	// full cycle keeps every segment in its own slot
	for (genvar g = 0; g < SEG_COUNT; g++) begin : g_order
		chk_order_kept: assert property (@(posedge core_clk) disable iff (reset)
			(!hold && (&mac_seg_valid)) |=> rx_segment_data[g] == $past(mac_seg_data[g]))
			else $error("segment order not kept");
		chk_order_flags: assert property (@(posedge core_clk) disable iff (reset)
			(!hold && (&mac_seg_valid)) |=> rx_segment_last[g] == $past(mac_seg_last[g]))
			else $error("segment flags out of order");
	end

	// transmit path reset follows its pin
	chk_tx_sync_rise: assert property ($rose(tx_path_reset_sync) |->
		$past(tx_path_reset, SYNC_STAGES) && $past(tx_path_reset, SYNC_STAGES + 1))
		else $error("transmit reset raised without pin");

	chk_tx_sync_fall: assert property ($fell(tx_path_reset_sync) |->
		!$past(tx_path_reset, SYNC_STAGES) && !$past(tx_path_reset, SYNC_STAGES + 1))
		else $error("transmit reset dropped without pin");
endmodule

// ---- srb_user_sink.sv ----
`timescale 1ns/1ps
module srb_user_sink
	import srb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [SEG_COUNT-1:0] seg_valid,
	input wire logic [SEG_COUNT-1:0] seg_last,
	output int end_count
);
	// counts packet ends, idle slots ignored
	always @(posedge core_clk) begin
		if (reset) begin
			end_count <= 0;
		end else begin
			end_count <= end_count + $countones(seg_valid & seg_last);
		end
	end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
	import srb_pkg::*;
;
	logic core_clk, reset, rx_path_reset, tx_path_reset, tx_sync;
	logic [SEG_COUNT-1:0] mv, mf, ml, mb, ov, of, ol, ob;
	srb_seg_t md [SEG_COUNT];
	srb_seg_t od [SEG_COUNT];
	srb_empty_t me [SEG_COUNT];
	srb_empty_t oe [SEG_COUNT];
	int miscompares, check_count, cycles, ends, exp_ends;
	srb_rx_bus dut_u (.core_clk(core_clk), .reset(reset), .rx_path_reset(rx_path_reset),
		.tx_path_reset(tx_path_reset), .tx_path_reset_sync(tx_sync), .mac_seg_valid(mv),
		.mac_seg_data(md), .mac_seg_first(mf), .mac_seg_last(ml), .mac_seg_bad(mb),
		.mac_seg_empty(me), .rx_segment_valid(ov), .rx_segment_data(od),
		.rx_segment_first(of), .rx_segment_last(ol), .rx_segment_bad(ob),
		.rx_segment_empty_bytes(oe));
	srb_user_sink sink_u (.core_clk(core_clk), .reset(reset), .seg_valid(ov),
		.seg_last(ol), .end_count(ends));
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// one cycle of segments, expectation packed toward segment zero
	task automatic xfer(input logic [3:0] v, input logic [3:0] f, input logic [3:0] l,
		input logic [3:0] b);
		int k;
		logic [3:0] ev, ef, el, eb;
		srb_seg_t ed [SEG_COUNT];
		srb_empty_t ee [SEG_COUNT];
		k = 0;
		ev = '0;
		ef = '0;
		el = '0;
		eb = '0;
		for (int i = 0; i < SEG_COUNT; i++) begin
			ed[i] = '0;
			ee[i] = '0;
			md[i] = {8{16'hA5C0 + 16'(i) + 16'(v) * 16'h10}};
			me[i] = 4'(i + 9);
			if (v[i]) begin
				ev[k] = 1'h1;
				ef[k] = f[i];
				el[k] = l[i];
				eb[k] = b[i] & l[i];
				ee[k] = l[i] ? me[i] : 4'h0;
				ed[k] = md[i];
				k++;
			end
		end
		exp_ends += $countones(v & l);
		mv = v;
		mf = f;
		ml = l;
		mb = b;
		@(posedge core_clk);
		#1;
		check(ov, ev);
		check(of, ef);
		check(ol, el);
		check(ob, eb);
		for (int i = 0; i < SEG_COUNT; i++) begin
			check(od[i], ed[i]);
			check(oe[i], ee[i]);
		end
	endtask
	// packet stream across every valid pattern
	task automatic stream_case;
		xfer(4'hA, 4'h2, 4'h8, 4'h0);
		for (int p = 0; p < 16; p++) begin
			xfer(p[3:0], ~p[3:0], 4'(p + 5), 4'(p * 3));
		end
		xfer(4'h0, 4'h0, 4'h0, 4'h0);
		check(ends, exp_ends);
	endtask
	// receive path reset drops traffic, bus live again after release
	task automatic rx_reset_case;
		rx_path_reset = 1;
		{mv, mf, ml} = {4'hF, 4'hF, 4'h0};
		repeat (5) @(posedge core_clk);
		#1;
		check(ov, 4'h0);
		mv = 4'h0;
		rx_path_reset = 0;
		repeat (6) @(posedge core_clk);
		#1;
		xfer(4'hF, 4'h1, 4'h8, 4'h8);
		xfer(4'h5, 4'h1, 4'h4, 4'h0);
		xfer(4'h0, 4'h0, 4'h0, 4'h0);
	endtask
	// transmit path reset through its synchroniser, receive bus unaffected
	task automatic tx_reset_case;
		tx_path_reset = 1;
		repeat (6) @(posedge core_clk);
		#1;
		check(tx_sync, 1'h1);
		xfer(4'h3, 4'h1, 4'h2, 4'h2);
		xfer(4'h0, 4'h0, 4'h0, 4'h0);
		tx_path_reset = 0;
		repeat (6) @(posedge core_clk);
		#1;
		check(tx_sync, 1'h0);
		check(ends, exp_ends);
	endtask
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 500) begin
			miscompares++;
			stop_test;
		end
	end
	initial begin
		{reset, rx_path_reset, tx_path_reset} = '1;
		{mv, mf, ml, mb} = '0;
		{miscompares, check_count, cycles, exp_ends} = '0;
		for (int i = 0; i < SEG_COUNT; i++) begin
			md[i] = '0;
			me[i] = '0;
		end
		repeat (16) @(posedge core_clk);
		#1;
		reset = 0;
		rx_path_reset = 0;
		tx_path_reset = 0;
		repeat (6) @(posedge core_clk);
		#1;
		stream_case;
		rx_reset_case;
		tx_reset_case;
		stop_test;
	end
endmodule
